// *** logic/scmc_top.sv ***
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - ch1-4: select 0 gives forced pwm, 1 gives power save
// - ch5-6: select 0 forced pwm; else dcm bit picks psm or dcm
// - clock on sync input drives all channels and pump; rate bits ignored
// - static sync uses internal oscillator at 2.0 or 1.5 MHz
// - internal master clock runs while enable is high and stops at the first master low phase after enable falls
// - each channel 1-6 runs at full or half master rate
// - phase bit clocks a full-rate channel from inverted master phase
// - half-rate channel always aligns to master rising edge
// - clock out pin carries ch1 clock if enabled and on internal source, else low
// - ch7 level chosen from 12, 9, 6, 5 V presets, fuse default
// - ch7 discharge only when enabled and ch7 is off
// - internal source: pump clock is master divided by 2,4,8,16
// - external source: pump divide only by four or eight
// - bootstrap shortfall of 2.5 V shuts down, no fault flagged
module scmc_top
  import scmc_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic enable_pin,
  input wire logic sync_pin,
  input wire logic [15:0] boot_short_mv,
  input wire logic [11:0] ss_fuse,
  input wire logic [1:0] lvl_fuse,
  // outputs
  output scmc_pkg::scmc_clk_s clk_o,
  output logic clock_out_pin,
  output scmc_pkg::scmc_mode_e [5:0] light_mode,
  output logic [5:0] soft_start_done,
  output logic [1:0] ch7_level,
  output logic ch7_discharge_on,
  output logic shutdown
);
  import scmc_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [31:0] mode_q;
  logic [31:0] clk_q;
  logic [11:0] ss_q;
  logic [5:0] ch7_q;
  logic fuse_done_q;
  logic en_s1_q, en_s2_q, sy_s1_q, sy_s2_q, sy_s3_q;
  logic [9:0] act_cnt_q;
  logic ext_q;
  scmc_src_e src_q;
  logic [7:0] div_cnt_q;
  logic master_q;
  logic [5:0] half_q;
  logic [3:0] pump_cnt_q;
  logic [5:0] chan_q;
  logic pump_q;
  logic cko_q;
  logic [5:0] ss_run_q;
  logic [31:0] ss_cnt_q [6];
  logic shut_q;
  logic [1:0] lvl_q;
  logic dsc_q;
  logic [5:0] llm_bits;

  wire wr_en = psel & penable & pwrite;
  wire mrise = (src_q == SCMC_INT) ? (div_cnt_q == 8'h00 && !master_q)
             : (sy_s2_q & ~sy_s3_q);
  wire mfall = (src_q == SCMC_INT) ? (div_cnt_q == 8'h00 && master_q)
             : (~sy_s2_q & sy_s3_q);

  // soft start length in pclk cycles for a two-bit code
  function automatic logic [31:0] ss_len(input logic [1:0] code);
    ss_len = 32'(SS_BASE_CYC) << code;
  endfunction

  // ****************************************************************
  // apb slave: zero wait, unmapped reads zero and error
  // ****************************************************************
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(paddr == ADDR_MODE ||
    paddr == ADDR_CLK || paddr == ADDR_SS || paddr == ADDR_CH7 ||
    paddr == ADDR_STAT);

  always_comb begin
    case (paddr)
      ADDR_MODE: prdata = mode_q;
      ADDR_CLK: prdata = clk_q;
      ADDR_SS: prdata = {20'h0, ss_q};
      ADDR_CH7: prdata = {26'h0, ch7_q};
      ADDR_STAT: prdata = {24'h0, shut_q, ext_q, ss_run_q};
      default: prdata = 32'h0;
    endcase
  end

  // config writes; fuse defaults captured after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
      clk_q <= CLK_RST;
      ss_q <= SS_FUSE_DEF;
      ch7_q <= {4'h0, LVL_FUSE_DEF};
      fuse_done_q <= 1'b0;
    end else if (!fuse_done_q) begin
      fuse_done_q <= 1'b1;
      ss_q <= ss_fuse;
      ch7_q <= {4'h0, lvl_fuse};
    end else if (wr_en) begin
      case (paddr)
        ADDR_MODE: mode_q <= pwdata;
        ADDR_CLK: clk_q <= pwdata;
        ADDR_SS: ss_q <= pwdata[11:0];
        ADDR_CH7: ch7_q <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // light load modes
  // ****************************************************************
  assign llm_bits = mode_q[LLS_LSB +: 6];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      light_mode[i] = llm_bits[i] ? SCMC_PSM : SCMC_FPWM;
    end
    for (int i = 4; i < 6; i++) begin
      if (!llm_bits[i]) begin
        light_mode[i] = SCMC_FPWM;
      end else begin
        light_mode[i] = mode_q[DCM_BIT] ? SCMC_DCM : SCMC_PSM;
      end
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      sy_s1_q <= 1'b0;
      sy_s2_q <= 1'b0;
      sy_s3_q <= 1'b0;
    end else begin
      en_s1_q <= enable_pin;
      en_s2_q <= en_s1_q;
      sy_s1_q <= sync_pin;
      sy_s2_q <= sy_s1_q;
      sy_s3_q <= sy_s2_q;
    end
  end

  // sync activity: any edge re-arms the timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_cnt_q <= 10'h0;
      ext_q <= 1'b0;
    end else if (sy_s2_q != sy_s3_q) begin
      act_cnt_q <= SYNC_TIMEOUT;
      ext_q <= 1'b1;
    end else if (act_cnt_q != 10'h0) begin
      act_cnt_q <= act_cnt_q - 10'h1;
    end else begin
      ext_q <= 1'b0;
    end
  end

  // internal source left only while master is low, so no runt high pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= SCMC_IDLE;
    end else begin
      case (src_q)
        SCMC_IDLE: if (ext_q) begin
          src_q <= SCMC_EXT;
        end else if (en_s2_q) begin
          src_q <= SCMC_INT;
        end
        // never leave on the edge that raises master, or it is a runt
        SCMC_INT: if ((ext_q || !en_s2_q) && !master_q && !mrise) begin
          src_q <= SCMC_IDLE;
        end
        // a sync parked high holds master high; after a whole timeout
        // without edges, dropping it is no runt
        SCMC_EXT: if (!ext_q) begin
          src_q <= SCMC_IDLE;
        end
        default: src_q <= SCMC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // master clock generation
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 8'h0;
    end else if (src_q != SCMC_INT || div_cnt_q == 8'h00) begin
      div_cnt_q <= (clk_q[MRS_BIT] ? SLOW_HALF : FAST_HALF) - 8'h1;
    end else begin
      div_cnt_q <= div_cnt_q - 8'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_q <= 1'b0;
    end else if (src_q == SCMC_IDLE) begin
      master_q <= 1'b0;
    end else if (mrise) begin
      master_q <= 1'b1;
    end else if (mfall) begin
      master_q <= 1'b0;
    end
  end

  // ****************************************************************
  // channel clocks
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 6'h0;
      chan_q <= 6'h0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (src_q == SCMC_IDLE) begin
          half_q[i] <= 1'b0;
          chan_q[i] <= 1'b0;
        end else if (mrise) begin
          half_q[i] <= ~half_q[i];
          // rate bit ignored under external sync
          if (clk_q[HRS_LSB + i] && src_q == SCMC_INT) begin
            chan_q[i] <= ~half_q[i];
          end else begin
            chan_q[i] <= ~clk_q[PHI_LSB + i];
          end
        end else if (mfall) begin
          if (!(clk_q[HRS_LSB + i] && src_q == SCMC_INT)) begin
            chan_q[i] <= clk_q[PHI_LSB + i];
          end
        end
      end
    end
  end

  // pump divider counts master rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_cnt_q <= 4'h0;
      pump_q <= 1'b0;
    end else if (src_q == SCMC_IDLE) begin
      pump_cnt_q <= 4'h0;
      pump_q <= 1'b0;
    end else if (mrise) begin
      pump_cnt_q <= pump_cnt_q + 4'h1;
      if (src_q == SCMC_EXT) begin
        // only divide by four or eight is offered
        pump_q <= clk_q[PDS_LSB] ? pump_cnt_q[2] : pump_cnt_q[1];
      end else begin
        pump_q <= pump_cnt_q[clk_q[PDS_LSB +: 2]];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cko_q <= 1'b0;
    end else begin
      cko_q <= clk_q[CKO_BIT] && src_q == SCMC_INT && chan_q[0];
    end
  end

  assign clk_o = '{chan_clk: chan_q, pump_clk: pump_q,
                   master_clk: master_q, ext_active: ext_q};
  assign clock_out_pin = cko_q;

  // ****************************************************************
  // soft start timers, started when enable rises
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_run_q <= 6'h0;
      for (int i = 0; i < 6; i++) begin
        ss_cnt_q[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (!en_s2_q || shut_q) begin
          ss_run_q[i] <= 1'b0;
          ss_cnt_q[i] <= ss_len(ss_q[2*i +: 2]);
        end else if (ss_cnt_q[i] != 32'h0) begin
          ss_cnt_q[i] <= ss_cnt_q[i] - 32'h1;
          ss_run_q[i] <= 1'b1;
        end else begin
          ss_run_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_start_done <= 6'h0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        soft_start_done[i] <= en_s2_q && !shut_q && ss_cnt_q[i] == 32'h0;
      end
    end
  end

  // ****************************************************************
  // channel 7 and bootstrap supervision
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 2'h0;
      dsc_q <= 1'b0;
      shut_q <= 1'b0;
    end else begin
      lvl_q <= ch7_q[LVL_LSB +: 2];
      dsc_q <= ch7_q[DSE_BIT] && !ch7_q[C7ON_BIT];
      // shutdown only; no voltage fault is raised
      shut_q <= boot_short_mv >= BOOT_DROP_MV;
    end
  end

  assign ch7_level = lvl_q;
  assign ch7_discharge_on = dsc_q;
  assign shutdown = shut_q;

endmodule // scmc_top

// *** common/scmc_pkg.sv ***
package scmc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned FAST_HZ = 2_000_000; // 2.0 MHz master
  localparam int unsigned SLOW_HZ = 1_500_000; // 1.5 MHz master
  // half period counts of the master clock, in pclk cycles
  localparam logic [7:0] FAST_HALF = 8'(CLK_HZ / FAST_HZ / 2);
  localparam logic [7:0] SLOW_HALF = 8'(CLK_HZ / SLOW_HZ / 2);
  // sync activity timeout: a few slow periods without an edge
  localparam logic [9:0] SYNC_TIMEOUT = 10'h258;
  localparam int unsigned SS_BASE_MS = 1;
  localparam int unsigned SS_BASE_CYC = CLK_HZ / 1000 * SS_BASE_MS;
  // supply shortfall threshold, 2.5 V in millivolts
  localparam logic [15:0] BOOT_DROP_MV = 16'h09c4;

  // ****************************************************************
  // apb register map
  // ****************************************************************
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CLK = 8'h04;
  localparam logic [7:0] ADDR_SS = 8'h08;
  localparam logic [7:0] ADDR_CH7 = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // mode register fields
  localparam int LLS_LSB = 0;   // [5:0] light_load_select
  localparam int DCM_BIT = 8;   // discontinuous_select_ch56
  // clock register fields
  localparam int HRS_LSB = 0;   // [5:0] channel_half_rate_sel
  localparam int PHI_LSB = 8;   // [13:8] channel_phase_invert
  localparam int MRS_BIT = 16;  // master_rate_sel
  localparam int CKO_BIT = 17;  // clock_out_enable
  localparam int PDS_LSB = 20;  // [21:20] pump_divider_sel
  // ch7 register fields
  localparam int LVL_LSB = 0;   // [1:0] ch7_level_sel
  localparam int DSE_BIT = 4;   // ch7_discharge_enable
  localparam int C7ON_BIT = 5;  // ch7 turned on

  // reset values
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] CLK_RST = 32'h0010_0000;
  localparam logic [11:0] SS_FUSE_DEF = 12'h000;
  localparam logic [1:0] LVL_FUSE_DEF = 2'h0;

  typedef enum logic [1:0] {
    SCMC_FPWM = 2'h0,
    SCMC_PSM = 2'h1,
    SCMC_DCM = 2'h2
  } scmc_mode_e;

  typedef enum logic [1:0] {
    SCMC_IDLE = 2'h0,
    SCMC_INT = 2'h1,
    SCMC_EXT = 2'h3
  } scmc_src_e;

  typedef struct packed {
    logic [5:0] chan_clk;
    logic pump_clk;
    logic master_clk;
    logic ext_active;
  } scmc_clk_s;

endpackage

// *** bench/scmc_properties.sv ***
`timescale 1ns/1ps
module scmc_properties
  import scmc_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // pins and outputs
  input wire logic enable_pin,
  input wire logic [15:0] boot_short_mv,
  input wire scmc_pkg::scmc_clk_s clk_o,
  input wire logic clock_out_pin,
  input wire scmc_pkg::scmc_mode_e [5:0] light_mode,
  input wire logic ch7_discharge_on,
  input wire logic shutdown
);
  logic [31:0] mode_q;
  logic [31:0] clk_q;
  logic [31:0] ch7_q;
  // long enough for a slow high half to finish before the stop
  localparam logic [7:0] IDLE_WAIT = 8'h96;
  logic [7:0] idle_cnt_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // shadow registers
  // ****************************************************************
  // only the fields the checks need; status and holes are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
      clk_q <= CLK_RST;
      ch7_q <= 32'h0;
    end else if (psel && penable && pwrite && pready) begin
      if (paddr == ADDR_MODE) mode_q <= pwdata;
      if (paddr == ADDR_CLK) clk_q <= pwdata;
      if (paddr == ADDR_CH7) ch7_q <= pwdata;
    end
  end
  // cycles with enable low and no sync, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= 8'h00;
    end else if (enable_pin || clk_o.ext_active) begin
      idle_cnt_q <= 8'h00;
    end else if (idle_cnt_q != IDLE_WAIT) begin
      idle_cnt_q <= idle_cnt_q + 8'h01;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  sequence int_idle;
    (idle_cnt_q == IDLE_WAIT) [*2];
  endsequence
  sequence ext_held;
    clk_o.ext_active [*3];
  endsequence
  ch1_mode_a: assert property (
    light_mode[0] == (mode_q[0] ? SCMC_PSM : SCMC_FPWM))
    else $error("ch1 light mode wrong");
  ch5_mode_a: assert property (
    light_mode[4] == (!mode_q[4] ? SCMC_FPWM :
      mode_q[DCM_BIT] ? SCMC_DCM : SCMC_PSM))
    else $error("ch5 light mode wrong");
  idle_stop_a: assert property (
    int_idle |-> !clk_o.master_clk && $stable(clk_o.master_clk))
    else $error("master clock runs while disabled");
  chan_edge_a: assert property (
    $rose(clk_o.chan_clk[0]) |->
      clk_o.master_clk != $past(clk_o.master_clk))
    else $error("ch1 edge not after master edge");
  half_align_a: assert property (
    $rose(clk_o.chan_clk[1]) && clk_q[1] && !clk_o.ext_active |->
      clk_o.master_clk && !$past(clk_o.master_clk))
    else $error("half rate edge off master rise");
  ext_low_a: assert property (
    ext_held |-> !clock_out_pin)
    else $error("clock out active under sync");
  drain_a: assert property (
    ch7_discharge_on ==
      ($past(ch7_q[DSE_BIT]) && !$past(ch7_q[C7ON_BIT])))
    else $error("ch7 discharge wrong");
  boot_stop_a: assert property (
    boot_short_mv >= BOOT_DROP_MV |=> shutdown)
    else $error("no shutdown on supply drop");
  ext_seen_c: cover property (ext_held);
endmodule // scmc_properties

bind scmc_top scmc_properties chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .enable_pin(enable_pin), .boot_short_mv(boot_short_mv),
  .clk_o(clk_o), .clock_out_pin(clock_out_pin),
  .light_mode(light_mode), .ch7_discharge_on(ch7_discharge_on),
  .shutdown(shutdown)
);

// *** bench/scmc_sync_src.sv ***
`timescale 1ns/1ps
module scmc_sync_src #(
  parameter real HALF_NS = 200.0
) (
  // control
  input wire logic run,
  input wire logic level,
  // sync pin
  output logic sync
);
  // free toggling only while run, else parked at a static level
  initial sync = 1'b0;
  always begin
    #(HALF_NS);
    if (run) sync = !sync;
    else sync = level;
  end
endmodule // scmc_sync_src

// *** bench/scmc_top_tb.sv ***
`timescale 1ns/1ps
module scmc_top_tb;
  import scmc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic enable_pin, sync_pin, run, level, rise_m;
  logic clock_out_pin, ch7_discharge_on, shutdown;
  logic [15:0] boot_short_mv;
  logic [5:0] soft_start_done;
  logic [1:0] ch7_level;
  scmc_clk_s clk_o;
  scmc_mode_e [5:0] light_mode;
  int bad_count, n_compared, n, i;
  // ****************************************************************
  // parts
  // ****************************************************************
  scmc_sync_src #(.HALF_NS(200.0)) src_u (
    .run(run), .level(level), .sync(sync_pin));
  scmc_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_pin(enable_pin),
    .sync_pin(sync_pin), .boot_short_mv(boot_short_mv),
    .ss_fuse(12'he4), .lvl_fuse(2'h3), .clk_o(clk_o),
    .clock_out_pin(clock_out_pin), .light_mode(light_mode),
    .soft_start_done(soft_start_done), .ch7_level(ch7_level),
    .ch7_discharge_on(ch7_discharge_on), .shutdown(shutdown));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer; #1 at the end lets the access edge land
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && c < 20) begin
      @(posedge pclk);
      c++;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // cycles between two rises of bit b of {clock_out_pin, clk_o}
  task chk_per(input int b, input int e);
    logic [9:0] v;
    logic p;
    int k, c;
    k = 0;
    c = 0;
    n = 0;
    p = 1'b1;
    while (k < 2 && c < 3 * e + 400) begin
      @(posedge pclk);
      #1;
      v = {clock_out_pin, clk_o};
      if (v[b] === 1'b1 && p !== 1'b1) k++;
      if (v[b] === 1'b1 && p !== 1'b1 && k == 1) rise_m = v[1];
      if (k == 1) n++;
      p = v[b];
      c++;
    end
    if (k < 2) n = 0;
    check(n, e);
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // clock, watchdog, tests
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // the tests need about 6500 cycles; allow about nine times that
  initial begin
    #(5 * 60000);
    bad_count++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {enable_pin, run, level, boot_short_mv, bad_count, n_compared} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(0, ADDR_CLK, 0);
    check(r, CLK_RST);
    apb(0, ADDR_MODE, 0);
    check(r, MODE_RST);
    check(32'(ch7_level), 32'h3);
    apb(0, ADDR_SS, 0);
    check(r, 32'h0000_00e4);
    apb(1, 8'h20, 32'h1);
    check(32'(err), 32'h1);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      apb(1, ADDR_MODE, {23'h0, i[1], 2'h0, {6{i[0]}}});
      check(light_mode[0], i[0] ? SCMC_PSM : SCMC_FPWM);
      check(light_mode[4], !i[0] ? SCMC_FPWM :
        i[1] ? SCMC_DCM : SCMC_PSM);
    end
    $display("mode test done");
    // ch2 half rate, ch1 inverted, clock out on, pump /4, 2.0 MHz
    @(posedge pclk);
    enable_pin <= 1'b1;
    apb(1, ADDR_CLK, 32'h0012_0102);
    // all six ramps running, none done yet
    apb(0, ADDR_STAT, 0);
    check(r, 32'h0000_003f);
    check(32'(soft_start_done), 32'h0);
    chk_per(1, 2 * FAST_HALF);
    chk_per(4, 4 * FAST_HALF);
    check(rise_m, 1'b1);
    chk_per(3, 2 * FAST_HALF);
    check(rise_m, 1'b0);
    chk_per(9, 2 * FAST_HALF);
    chk_per(2, 8 * FAST_HALF);
    apb(1, ADDR_CLK, 32'h0011_0000);
    chk_per(1, 2 * SLOW_HALF);
    chk_per(2, 8 * SLOW_HALF);
    chk_per(9, 0);
    @(posedge pclk);
    enable_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    chk_per(1, 0);
    $display("internal clock test done");
    @(posedge pclk);
    run <= 1'b1;
    repeat (200) @(posedge pclk);
    enable_pin <= 1'b1;
    apb(1, ADDR_CLK, 32'h0013_003f);
    repeat (300) @(posedge pclk);
    check(32'(clk_o.ext_active), 32'h1);
    chk_per(1, 80);
    chk_per(4, 80);
    chk_per(2, 640);
    chk_per(9, 0);
    @(posedge pclk);
    run <= 1'b0;
    level <= 1'b1;
    repeat (700) @(posedge pclk);
    check(32'(clk_o.ext_active), 32'h0);
    chk_per(4, 4 * SLOW_HALF);
    $display("sync test done");
    apb(1, ADDR_CH7, 32'h12);
    repeat (3) @(posedge pclk);
    check(32'(ch7_discharge_on), 32'h1);
    check(32'(ch7_level), 32'h2);
    apb(1, ADDR_CH7, 32'h30);
    repeat (3) @(posedge pclk);
    check(32'(ch7_discharge_on), 32'h0);
    boot_short_mv <= BOOT_DROP_MV - 16'h1;
    repeat (3) @(posedge pclk);
    check(32'(shutdown), 32'h0);
    boot_short_mv <= BOOT_DROP_MV;
    repeat (3) @(posedge pclk);
    check(32'(shutdown), 32'h1);
    $display("ch7 and supply test done");
    give_verdict;
  end
endmodule // scmc_top_tb
